/* File: logic/sacs_pkg.sv */
// ==========================================================
// Purpose: Constants and carriers for the converter sequencer
// Assumes: 25 MHz ref_clk, parallel read of eight channels
// Notes:   Times in ns, cycle counts derived from them
package sacs_pkg;
   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 40;
   function automatic int min_cyc(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction
   function automatic int max_cyc(input int ns);
      int c;
      c = ns / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction
   localparam int T_RESET_NS         = 50;
   localparam int RESET_CYC          = min_cyc(T_RESET_NS);
   localparam int T_RST_GAP_NS       = 25;
   localparam int RST_GAP_CYC        = min_cyc(T_RST_GAP_NS);
   localparam int T_CONV_HIGH_NS     = 25;
   localparam int CONV_HIGH_CYC      = min_cyc(T_CONV_HIGH_NS);
   localparam int T_CONV_LOW_NS      = 25;
   localparam int CONV_LOW_CYC       = min_cyc(T_CONV_LOW_NS);
   localparam int T_BUSY_RISE_NS     = 40;
   localparam int BUSY_GUARD_CYC     = max_cyc(T_BUSY_RISE_NS) + 1;
   localparam int T_RD_LOW_NS        = 32;
   localparam int RD_LOW_CYC         = min_cyc(T_RD_LOW_NS);
   localparam int T_RD_HIGH_NS       = 22;
   localparam int RD_HIGH_CYC        = min_cyc(T_RD_HIGH_NS);
   localparam int T_CYCLE_NS         = 5000;
   localparam int CYCLE_CYC          = min_cyc(T_CYCLE_NS);
   localparam int T_WAKE_LOW_POWER_REQUEST_N_NS     = 100000;
   localparam int WAKE_LOW_POWER_REQUEST_N_CYC      = min_cyc(T_WAKE_LOW_POWER_REQUEST_N_NS);
   localparam int T_WAKE_SHUT_INT_NS = 30000000;
   localparam int T_WAKE_SHUT_EXT_NS = 13000000;
   localparam int T_CONV_OS64_NS     = 315000;
   localparam int TMO_MARGIN_CYC     = 1;
   // Worst conversion time per oversampling code, 64 handled by the top
   function automatic int tconv_max_ns(input logic [2:0] os);
      case (os)
         3'h1:    return 9100;
         3'h2:    return 18800;
         3'h3:    return 39000;
         3'h4:    return 78000;
         3'h5:    return 158000;
         default: return 4200;
      endcase
   endfunction
   // ==========================================================
   // Sizes and register map
   localparam int DATA_W = 16;
   localparam int ADDR_W = 4;
   localparam int NUM_CH = 8;
   localparam int CNT_W  = 20;
   localparam logic [ADDR_W-1:0] ADDR_CTRL     = 4'h0;
   localparam logic [ADDR_W-1:0] ADDR_CMD      = 4'h1;
   localparam logic [ADDR_W-1:0] ADDR_STATUS   = 4'h2;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 4'h3;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 4'h4;
   localparam logic [ADDR_W-1:0] ADDR_RESULT   = 4'h8;
   localparam int CTRL_RUN_BIT    = 0;
   localparam int CTRL_DEEP_BIT   = 1;
   localparam int CTRL_REFEXT_BIT = 2;
   localparam int CTRL_OS_LSB     = 3;
   localparam int CMD_START_BIT   = 0;
   localparam int CMD_RESET_BIT   = 1;
   localparam int IRQ_W           = 3;
   localparam int IRQ_DONE_BIT    = 0;
   localparam int IRQ_TMO_BIT     = 1;
   localparam int IRQ_REFUSE_BIT  = 2;
   localparam logic [5:0]       CTRL_RST = 6'h01;
   localparam logic [2:0]       OS_INVALID = 3'h7;
   // ==========================================================
   // Carriers
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } sacs_bus_s;
   typedef struct packed {
      logic       conversion_start_group_a;
      logic       conversion_start_group_b;
      logic [2:0] oversample_ratio_select;
      logic       low_power_request_n;
      logic       dev_reset;
      logic       cs_n;
      logic       rd_n;
   } sacs_pins_s;
endpackage

/* File: logic/sacs_result_mem.sv */
// ==========================================================
// Purpose: Result store, one word per channel
// Assumes: Separate write and read ports, one clock
// Notes:   Read data come out of a register one cycle later
`timescale 1ns/1ps
module sacs_result_mem #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic                     ref_clk,
   input  wire logic                     we,
   input  wire logic [$clog2(DEPTH)-1:0] waddr,
   input  wire logic [WIDTH-1:0]         wdata,
   input  wire logic                     re,
   input  wire logic [$clog2(DEPTH)-1:0] raddr,
   output logic      [WIDTH-1:0]         rdata
);
   logic [WIDTH-1:0] mem [DEPTH];
   // No reset: contents are only meaningful after a completed read-out
   always_ff @(posedge ref_clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      if (re) begin
         rdata <= mem[raddr];
      end
   end
endmodule // sacs_result_mem

/* File: logic/sacs_host.sv */
// ==========================================================
// Purpose: Host sequencer for an eight-channel sampling converter
// Assumes: Parallel read after conversion, pins synchronous
// Notes:   Registers on a plain strobe port, read data next cycle
`timescale 1ns/1ps
module sacs_host #(
   parameter int WAKE_SHUT_INT_CYC = sacs_pkg::min_cyc(sacs_pkg::T_WAKE_SHUT_INT_NS),
   parameter int WAKE_SHUT_EXT_CYC = sacs_pkg::min_cyc(sacs_pkg::T_WAKE_SHUT_EXT_NS),
   parameter int BUSY_TMO_OS64_CYC = sacs_pkg::min_cyc(sacs_pkg::T_CONV_OS64_NS) + 1
) (
   input  wire logic                        ref_clk,
   input  wire logic                        rst_n,
   input  wire sacs_pkg::sacs_bus_s         bus,
   output logic      [sacs_pkg::DATA_W-1:0] rdata,
   output logic                             irq,
   output sacs_pkg::sacs_pins_s             pins,
   input  wire logic                        busy,
   input  wire logic [sacs_pkg::DATA_W-1:0] db
);
   localparam int CW = sacs_pkg::CNT_W;
   localparam int IRQ_W_L = sacs_pkg::IRQ_W;
   typedef enum logic [3:0] {
      ST_IDLE, ST_WAKE, ST_CONV_HI, ST_WAIT_BUSY, ST_READ_LO,
      ST_READ_HI, ST_SPACE, ST_RST_HI, ST_RST_GAP
   } sacs_state_e;

   // ==========================================================
   // State
   sacs_state_e          state, next_state;
   logic [CW-1:0]        cnt, next_cnt;
   logic [2:0]           idx, next_idx;
   logic [7:0]           cyc, next_cyc;
   sacs_pkg::sacs_pins_s next_pins;
   logic [5:0]           ctrl, next_ctrl;
   logic [IRQ_W_L-1:0]   irq_stat, next_irq_stat;
   logic [IRQ_W_L-1:0]   irq_mask, next_irq_mask;
   logic                 pend, next_pend;
   logic                 valid, next_valid;
   logic                 sel_mem, next_sel_mem;
   logic [15:0]          reg_q, next_reg_q;
   logic [15:0]          mem_q;
   logic                 take_start, ev_done, ev_tmo, mem_we;
   logic                 wr_ctrl, cmd_start, cmd_reset, refuse;
   logic [CW-1:0]        tmo_cyc, wake_cyc;
   logic [2:0]           ctrl_os;

   // Command decode
   assign wr_ctrl   = bus.wr && (bus.addr == sacs_pkg::ADDR_CTRL);
   assign cmd_start = bus.wr && (bus.addr == sacs_pkg::ADDR_CMD)
                      && bus.wdata[sacs_pkg::CMD_START_BIT];
   assign cmd_reset = bus.wr && (bus.addr == sacs_pkg::ADDR_CMD)
                      && bus.wdata[sacs_pkg::CMD_RESET_BIT];
   assign refuse    = cmd_start && (!ctrl[sacs_pkg::CTRL_RUN_BIT] || pend);
   assign ctrl_os   = ctrl[sacs_pkg::CTRL_OS_LSB +: 3];

   // ratio-dependent timeout
   // Timeout sits one cycle past the worst conversion of the ratio in use
   always_comb begin
      if (pins.oversample_ratio_select == 3'h6) begin
         tmo_cyc = CW'(BUSY_TMO_OS64_CYC);
      end else begin
         tmo_cyc = CW'(sacs_pkg::min_cyc(sacs_pkg::tconv_max_ns(pins.oversample_ratio_select))
                       + sacs_pkg::TMO_MARGIN_CYC);
      end
   end

   always_comb begin
      if (!ctrl[sacs_pkg::CTRL_DEEP_BIT]) begin
         wake_cyc = CW'(sacs_pkg::WAKE_LOW_POWER_REQUEST_N_CYC);
      end else if (ctrl[sacs_pkg::CTRL_REFEXT_BIT]) begin
         wake_cyc = CW'(WAKE_SHUT_EXT_CYC);
      end else begin
         wake_cyc = CW'(WAKE_SHUT_INT_CYC);
      end
   end

   // ==========================================================
   // Sequencer
   always_comb begin
      next_state = state;
      next_cnt   = cnt;
      next_idx   = idx;
      next_cyc   = (cyc != 8'h00) ? cyc - 8'h01 : cyc;
      next_pins  = pins;
      take_start = 1'b0;
      ev_done    = 1'b0;
      ev_tmo     = 1'b0;
      mem_we     = 1'b0;
      case (state)
         ST_IDLE: begin
            // select only moves while idle, far from any busy edge
            if (pins.oversample_ratio_select != ctrl_os) begin
               next_pins.oversample_ratio_select = ctrl_os;
            end else if (!ctrl[sacs_pkg::CTRL_RUN_BIT]) begin
               next_pins.low_power_request_n = 1'b0;
            end else if (!pins.low_power_request_n) begin
               next_pins.low_power_request_n = 1'b1;
               next_state = ST_WAKE;
               next_cnt   = wake_cyc - CW'(1);
            end else if (pend) begin
               next_pins.conversion_start_group_a = 1'b1;
               next_pins.conversion_start_group_b = 1'b1;
               take_start = 1'b1;
               next_state = ST_CONV_HI;
               next_cnt   = CW'(sacs_pkg::CONV_HIGH_CYC - 1);
               next_cyc   = 8'(sacs_pkg::CYCLE_CYC - 1);
            end
         end
         ST_WAKE: begin
            if (cnt == '0) begin
               next_state = ST_IDLE;
            end else begin
               next_cnt = cnt - CW'(1);
            end
         end
         ST_CONV_HI: begin
            if (cnt == '0) begin
               next_pins.conversion_start_group_a = 1'b0;
               next_pins.conversion_start_group_b = 1'b0;
               next_state = ST_WAIT_BUSY;
               next_cnt   = '0;
            end else begin
               next_cnt = cnt - CW'(1);
            end
         end
         ST_WAIT_BUSY: begin
            next_cnt = cnt + CW'(1);
            // ignore busy until the device had time to raise it
            // chip select falls only once busy is seen low
            if (cnt >= CW'(sacs_pkg::BUSY_GUARD_CYC) && !busy) begin
               next_pins.cs_n = 1'b0;
               next_pins.rd_n = 1'b0;
               next_idx   = 3'h0;
               next_state = ST_READ_LO;
               next_cnt   = CW'(sacs_pkg::RD_LOW_CYC - 1);
            end else if (cnt >= tmo_cyc) begin
               ev_tmo     = 1'b1;
               next_state = ST_SPACE;
               next_cnt   = CW'(sacs_pkg::CONV_LOW_CYC - 1);
            end
         end
         ST_READ_LO: begin
            // one word per channel, sampled at the end of the strobe
            if (cnt == '0) begin
               mem_we         = 1'b1;
               next_pins.cs_n = 1'b1;
               next_pins.rd_n = 1'b1;
               next_state     = ST_READ_HI;
               next_cnt       = CW'(sacs_pkg::RD_HIGH_CYC - 1);
            end else begin
               next_cnt = cnt - CW'(1);
            end
         end
         ST_READ_HI: begin
            if (cnt != '0) begin
               next_cnt = cnt - CW'(1);
            end else if (idx == 3'(sacs_pkg::NUM_CH - 1)) begin
               ev_done    = 1'b1;
               next_state = ST_SPACE;
               next_cnt   = CW'(sacs_pkg::CONV_LOW_CYC - 1);
            end else begin
               next_idx       = idx + 3'h1;
               next_pins.cs_n = 1'b0;
               next_pins.rd_n = 1'b0;
               next_state     = ST_READ_LO;
               next_cnt       = CW'(sacs_pkg::RD_LOW_CYC - 1);
            end
         end
         ST_SPACE: begin
            // throughput spacing; serial periods unused, parallel only
            // every read follows busy, none straddles its fall
            if (cnt != '0) begin
               next_cnt = cnt - CW'(1);
            end else if (cyc == 8'h00) begin
               next_state = ST_IDLE;
            end
         end
         ST_RST_HI: begin
            if (cnt == '0) begin
               next_pins.dev_reset = 1'b0;
               next_state = ST_RST_GAP;
               next_cnt   = CW'(sacs_pkg::RST_GAP_CYC - 1);
            end else begin
               next_cnt = cnt - CW'(1);
            end
         end
         ST_RST_GAP: begin
            if (cnt == '0) begin
               next_state = ST_IDLE;
            end else begin
               next_cnt = cnt - CW'(1);
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      // Reset command overrides any sequence in flight
      if (cmd_reset) begin
         next_pins.dev_reset                = 1'b1;
         next_pins.conversion_start_group_a = 1'b0;
         next_pins.conversion_start_group_b = 1'b0;
         next_pins.cs_n                     = 1'b1;
         next_pins.rd_n                     = 1'b1;
         next_state = ST_RST_HI;
         next_cnt   = CW'(sacs_pkg::RESET_CYC - 1);
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         cnt   <= '0;
         idx   <= 3'h0;
         cyc   <= 8'h00;
         pins  <= '{1'b0, 1'b0, 3'h0, 1'b1, 1'b0, 1'b1, 1'b1};
      end else begin
         state <= next_state;
         cnt   <= next_cnt;
         idx   <= next_idx;
         cyc   <= next_cyc;
         pins  <= next_pins;
      end
   end

   // ==========================================================
   // Registers and interrupt
   always_comb begin
      next_ctrl     = ctrl;
      next_irq_mask = irq_mask;
      next_reg_q    = reg_q;
      next_sel_mem  = 1'b0;
      next_pend     = pend;
      next_valid    = valid;
      if (wr_ctrl) begin
         next_ctrl = bus.wdata[5:0];
         // Reserved ratio code falls back to no oversampling
         if (bus.wdata[sacs_pkg::CTRL_OS_LSB +: 3] == sacs_pkg::OS_INVALID) begin
            next_ctrl[sacs_pkg::CTRL_OS_LSB +: 3] = 3'h0;
         end
      end
      if (bus.wr && bus.addr == sacs_pkg::ADDR_IRQ_MASK) begin
         next_irq_mask = bus.wdata[IRQ_W_L-1:0];
      end
      // Set wins over write-one-to-clear
      next_irq_stat = irq_stat;
      if (bus.wr && bus.addr == sacs_pkg::ADDR_IRQ_STAT) begin
         next_irq_stat = irq_stat & ~bus.wdata[IRQ_W_L-1:0];
      end
      next_irq_stat[sacs_pkg::IRQ_DONE_BIT]   = next_irq_stat[sacs_pkg::IRQ_DONE_BIT] | ev_done;
      next_irq_stat[sacs_pkg::IRQ_TMO_BIT]    = next_irq_stat[sacs_pkg::IRQ_TMO_BIT] | ev_tmo;
      next_irq_stat[sacs_pkg::IRQ_REFUSE_BIT] = next_irq_stat[sacs_pkg::IRQ_REFUSE_BIT] | refuse;
      // A start waits as pending until the sequencer is idle and awake
      if (take_start || cmd_reset) begin
         next_pend = 1'b0;
      end else if (cmd_start && !refuse) begin
         next_pend = 1'b1;
      end
      if (take_start) begin
         next_valid = 1'b0;
      end else if (ev_done) begin
         next_valid = 1'b1;
      end
      // Read decode, unmapped reads return zero
      if (bus.rd) begin
         if (bus.addr >= sacs_pkg::ADDR_RESULT) begin
            next_sel_mem = 1'b1;
         end else if (bus.addr == sacs_pkg::ADDR_CTRL) begin
            next_reg_q = {10'h000, ctrl};
         end else if (bus.addr == sacs_pkg::ADDR_STATUS) begin
            next_reg_q = {11'h000, valid, pend, busy,
                          pins.low_power_request_n && state != ST_WAKE, state != ST_IDLE};
         end else if (bus.addr == sacs_pkg::ADDR_IRQ_STAT) begin
            next_reg_q = {13'h0000, irq_stat};
         end else if (bus.addr == sacs_pkg::ADDR_IRQ_MASK) begin
            next_reg_q = {13'h0000, irq_mask};
         end else begin
            next_reg_q = 16'h0000;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl     <= sacs_pkg::CTRL_RST;
         irq_stat <= '0;
         irq_mask <= '0;
         reg_q    <= 16'h0000;
         sel_mem  <= 1'b0;
         pend     <= 1'b0;
         valid    <= 1'b0;
      end else begin
         ctrl     <= next_ctrl;
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
         reg_q    <= next_reg_q;
         sel_mem  <= next_sel_mem;
         pend     <= next_pend;
         valid    <= next_valid;
      end
   end

   assign rdata = sel_mem ? mem_q : reg_q;
   assign irq   = |(irq_stat & irq_mask);

   sacs_result_mem #(.WIDTH(sacs_pkg::DATA_W), .DEPTH(sacs_pkg::NUM_CH)) u_mem (
      .ref_clk (ref_clk),
      .we      (mem_we),
      .waddr   (idx),
      .wdata   (db),
      .re      (bus.rd),
      .raddr   (bus.addr[2:0]),
      .rdata   (mem_q)
   );

   // ==========================================================
   // Checks
   logic [7:0]    since_conv;
   logic [CW-1:0] since_wake;
   // Helper ages, saturating
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         since_conv <= 8'hFF;
         since_wake <= '1;
      end else begin
         since_conv <= next_pins.conversion_start_group_a && !pins.conversion_start_group_a
                       ? 8'h00 : (since_conv == 8'hFF ? since_conv : since_conv + 8'h01);
         since_wake <= next_pins.low_power_request_n && !pins.low_power_request_n
                       ? '0 : (&since_wake ? since_wake : since_wake + CW'(1));
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   a_reset_pulse_len: assert property ($rose(pins.dev_reset) |-> pins.dev_reset [*2])
      else $error("device reset pulse too short");
   a_reset_start_gap: assert property ($fell(pins.dev_reset) |-> !pins.conversion_start_group_a)
      else $error("start too soon after reset");
   a_groups_paired: assert property (pins.conversion_start_group_a == pins.conversion_start_group_b)
      else $error("group starts not paired");
   a_start_pulse_shape: assert property ($rose(pins.conversion_start_group_a)
      |=> !pins.conversion_start_group_a ##1 !pins.conversion_start_group_a)
      else $error("start pulse shape wrong");
   a_cycle_spacing: assert property ($rose(pins.conversion_start_group_a)
      |-> $past(since_conv) >= 8'(sacs_pkg::CYCLE_CYC - 1))
      else $error("conversions too close");
   a_os_stable_busy: assert property ((busy || $past(busy)) |-> $stable(pins.oversample_ratio_select))
      else $error("ratio select moved near busy");
   a_cs_after_busy: assert property ($fell(pins.cs_n) |-> !$past(busy))
      else $error("chip select before busy fell");
   a_wake_delay: assert property ($rose(pins.conversion_start_group_a)
      |-> since_wake >= CW'(sacs_pkg::WAKE_LOW_POWER_REQUEST_N_CYC))
      else $error("start before wake time");
   a_read_linked: assert property (pins.cs_n == pins.rd_n)
      else $error("chip select and read strobe split");
   c_conv_done: cover property (ev_done);
   c_conv_tmo: cover property (ev_tmo);
   c_wake_start: cover property (take_start && since_wake < CW'(sacs_pkg::WAKE_LOW_POWER_REQUEST_N_CYC + 8));
endmodule // sacs_host

/* File: tb/sacs_dev_model.sv */
// Purpose: Behavioural eight-channel sampling converter
// Assumes: Host pins move on its own clock
// Notes:   Host timing faults are counted in viol
`timescale 1ns/1ps
module sacs_dev_model (
   input  wire sacs_pkg::sacs_pins_s pins,
   input  wire logic                 stall,
   input  wire logic [15:0]          base,
   output logic                      busy,
   output logic [15:0]               db,
   output int                        viol
);
   int         cnv [7] = '{4000, 8500, 17500, 36000, 72000, 145000, 290000};
   realtime    ta = -1e6, tb = 0, tr = -1e6, tl = -1e6, th = -1e6, tw = -1e6;
   logic [2:0] os;
   logic [2:0] ch;
   initial begin
      busy = 1'b0;
      db = 16'h0;
      viol = 0;
   end
   // ==========================================================
   // Conversion
   // start spacing checks
   always @(posedge pins.conversion_start_group_a) begin
      if ($realtime - ta < 5000 || $realtime - tr < 25 || $realtime - tl < 25
          || $realtime - tw < 100000) viol++;
      ta = $realtime;
      #10 busy = 1'b1;
      os = pins.oversample_ratio_select;
      ch = 3'h0;
      #(cnv[os]);
      wait (!stall);
      if (os !== pins.oversample_ratio_select || ta - tb > 5e5 || tb - ta > 5e5) viol++;
      busy = 1'b0;
   end
   always @(negedge pins.conversion_start_group_a) begin
      if ($realtime - ta < 25) viol++;
      tl = $realtime;
   end
   always @(posedge pins.conversion_start_group_b) tb = $realtime;
   // asleep blocks starts, wake time counted from the rise
   always @(negedge pins.low_power_request_n) tw = 1e12;
   always @(posedge pins.low_power_request_n) if (tw > 1e11) tw = $realtime;
   always @(negedge pins.cs_n) if (busy) viol++;
   always @(negedge pins.dev_reset) begin
      if ($realtime - th < 50) viol++;
      tr = $realtime;
   end
   always @(posedge pins.dev_reset) th = $realtime;
   // ==========================================================
   // Read port: released bus shows the inverse, not a held value
   always @(negedge pins.rd_n) #20 db = base ^ {13'h0, ch};
   always @(posedge pins.rd_n) begin
      ch = ch + 3'h1;
      db = ~db;
   end
endmodule // sacs_dev_model

/* File: tb/sacs_host_test.sv */
// Purpose: Self-checking bench of the converter sequencer
// Assumes: Device model answers on the pins
// Notes:   Reads queue expectations; a monitor compares
`timescale 1ns/1ps
module sacs_host_test;
   logic                 ref_clk, rst_n, busy, irq, stall, pend;
   logic [15:0]          rdata, db, base;
   sacs_pkg::sacs_bus_s  bus;
   sacs_pkg::sacs_pins_s pins;
   logic [15:0]          exp_q [$];
   int                   num_errors, check_count, viol, cyc, hi;
   sacs_host #(.WAKE_SHUT_INT_CYC(50), .WAKE_SHUT_EXT_CYC(50)) dut (.ref_clk(ref_clk),
      .rst_n(rst_n), .bus(bus), .rdata(rdata), .irq(irq), .pins(pins), .busy(busy), .db(db));
   sacs_dev_model model (.pins(pins), .stall(stall), .base(base), .busy(busy), .db(db),
      .viol(viol));
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // ==========================================================
   // Checks and bus cycles
   task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk);
      bus <= '0;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      bus <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk);
      bus <= '0;
      @(posedge ref_clk);
   endtask
   task automatic wait_irq();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 20000) begin
         @(posedge ref_clk);
         n++;
      end
      check("irq raised", 16'h1, 16'(irq));
   endtask
   task automatic report_and_stop();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Read data stand in the cycle after the strobe, result words only then
   always @(negedge ref_clk) begin
      if (pend) check("rdata", exp_q.pop_front(), rdata);
      pend = bus.rd;
      hi += int'(pins.dev_reset === 1'b1);
   end
   // Hang guard, well above the longest run
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 60000) begin
         num_errors++;
         report_and_stop();
      end
   end
   // ==========================================================
   // Main sequence
   initial begin
      bus = '0;
      rst_n = 1'b0;
      stall = 1'b0;
      base = 16'h0;
      pend = 1'b0;
      void'($urandom(32'h02d096fa));
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      rd(sacs_pkg::ADDR_CTRL, 16'h0001);
      rd(4'h5, 16'h0000);
      wr(sacs_pkg::ADDR_IRQ_MASK, 16'h0007);
      wr(sacs_pkg::ADDR_CMD, 16'h0002);
      repeat (4) @(posedge ref_clk);
      check("reset cycles", 16'h2, 16'(hi));
      for (int os = 0; os < 7; os++) begin
         base <= 16'($urandom);
         wr(sacs_pkg::ADDR_CTRL, 16'(1 + (os << 3)));
         wr(sacs_pkg::ADDR_CMD, 16'h0001);
         wait_irq();
         for (int c = 0; c < 8; c++) rd(4'(8 + c), base ^ 16'(c));
         rd(sacs_pkg::ADDR_IRQ_STAT, 16'h0001);
         rd(sacs_pkg::ADDR_STATUS, 16'h0012);
         wr(sacs_pkg::ADDR_IRQ_STAT, 16'h0007);
         check("irq cleared", 16'h0, 16'(irq));
      end
      stall <= 1'b1;
      wr(sacs_pkg::ADDR_CTRL, 16'h0001);
      wr(sacs_pkg::ADDR_CMD, 16'h0001);
      wait_irq();
      rd(sacs_pkg::ADDR_IRQ_STAT, 16'h0002);
      stall <= 1'b0;
      while (busy) @(posedge ref_clk);
      wr(sacs_pkg::ADDR_IRQ_STAT, 16'h0007);
      wr(sacs_pkg::ADDR_IRQ_MASK, 16'h0003);
      wr(sacs_pkg::ADDR_CTRL, 16'h0000);
      wr(sacs_pkg::ADDR_CMD, 16'h0001);
      check("masked irq", 16'h0, 16'(irq));
      rd(sacs_pkg::ADDR_IRQ_STAT, 16'h0004);
      rd(sacs_pkg::ADDR_IRQ_MASK, 16'h0003);
      // Let the sequencer drop into low power, then wake and convert
      repeat (8) @(posedge ref_clk);
      rd(sacs_pkg::ADDR_STATUS, 16'h0000);
      wr(sacs_pkg::ADDR_CTRL, 16'h0001);
      wr(sacs_pkg::ADDR_CMD, 16'h0001);
      wait_irq();
      rd(sacs_pkg::ADDR_IRQ_STAT, 16'h0005);
      check("pin faults", 16'h0, 16'(viol));
      report_and_stop();
   end
endmodule // sacs_host_test
